// ---- design/flash_seq.sv ----
// in-application erase and program sequencer for on-chip flash
// assumes a cpu register port on clk, a flash macro answering a one-cycle start
//
// The register offsets and the strobed register port were chosen for this implementation.
`include "flash_seq_consts.svh"

module flash_seq #(
  parameter int ERASE_CNT = `ERASE_CYCLES,
  parameter int PROG_CNT = `PROG_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire flash_seq_pkg::reg_req_t req, // register access from cpu
  input wire logic main_write_block, // option: main area writes blocked
  input wire logic exec_from_boot, // cpu currently runs boot-area code
  input wire logic flash_done, // flash macro finished operation
  output logic [7:0] rdata, // read data, cycle after read strobe
  output logic cpu_hold, // holds cpu program counter
  output logic flash_start, // one-cycle start to flash macro
  output flash_seq_pkg::flash_cmd_t flash_cmd, // operation for flash macro
  output logic boot_read_ok, // code reads may target boot area
  output logic boot_after_reset // boot from boot area after soft reset
);
  localparam int CW = 16;
  logic [7:0] key_reg, key_next, region_reg, region_next, data_reg, data_next;
  logic [15:0] addr_reg, addr_next;
  logic [7:0] ctrl_reg, ctrl_next, rdata_reg, rdata_next;
  logic unlock_reg, unlock_next, refused_reg, refused_next;
  logic [7:0] win_reg, win_next;
  logic [CW-1:0] busy_reg, busy_next;
  flash_seq_pkg::seq_state_t st_reg, st_next;
  logic start_reg, start_next, boot_ok_reg, boot_ok_next;
  logic hold_reg, hold_next;
  flash_seq_pkg::flash_cmd_t cmd_reg, cmd_next;
  logic ctrl_wr, exec_req, one_op, region_ok;

  //////////////////////////////////////////////////////////////////////////
  // command decode
  assign ctrl_wr = req.wr && (req.addr == `OFS_CTRL);
  assign exec_req = ctrl_wr && (req.wdata[1:0] == `CMD_EXECUTE);
  assign one_op = req.wdata[`CTRL_ERASE_BIT] ^ req.wdata[`CTRL_PROG_BIT];
  // only main (unless blocked) and eeprom accept writes
  always_comb begin
    region_ok = 1'b0;
    if (region_reg == `REGION_MAIN) begin
      region_ok = !main_write_block;
    end else if (region_reg == `REGION_EEPROM) begin
      region_ok = 1'b1;
    end
    // identifier, boot and reserved codes stay refused
  end

  //////////////////////////////////////////////////////////////////////////
  // register file and read-back
  always_comb begin
    key_next = key_reg;
    region_next = region_reg;
    data_next = data_reg;
    addr_next = addr_reg;
    ctrl_next = ctrl_reg;
    rdata_next = `RESET_BYTE; // only valid the cycle after a read
    if (req.wr) begin
      unique case (req.addr)
        `OFS_KEY: key_next = req.wdata;
        `OFS_ADDR_LO: addr_next[7:0] = req.wdata;
        `OFS_ADDR_HI: addr_next[15:8] = req.wdata;
        `OFS_REGION: region_next = req.wdata;
        `OFS_DATA: data_next = req.wdata;
        `OFS_CTRL: ctrl_next = {req.wdata[7], 1'b0, req.wdata[5:4], 2'b00, req.wdata[1:0]};
        default: ;
      endcase
    end
    if (req.rd) begin
      unique case (req.addr)
        `OFS_KEY: rdata_next = key_reg;
        `OFS_ADDR_LO: rdata_next = addr_reg[7:0];
        `OFS_ADDR_HI: rdata_next = addr_reg[15:8];
        `OFS_REGION: rdata_next = region_reg;
        `OFS_DATA: rdata_next = data_reg;
        `OFS_CTRL: rdata_next = ctrl_reg;
        `OFS_STATUS: rdata_next = {5'h00, refused_reg, st_reg != flash_seq_pkg::st_idle,
                                   unlock_reg};
        default: rdata_next = `RESET_BYTE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // unlock window: key value n counts down, execute within it or relock
  always_comb begin
    unlock_next = unlock_reg;
    win_next = win_reg;
    refused_next = refused_reg;
    if (req.wr && req.addr == `OFS_KEY) begin
      unlock_next = (req.wdata != 8'h00);
      win_next = req.wdata;
    end else if (exec_req) begin
      unlock_next = 1'b0; // key used once
      win_next = 8'h00;
    end else if (unlock_reg) begin
      if (win_reg <= 8'h01) begin
        unlock_next = 1'b0;
      end
      win_next = win_reg - 8'h01;
    end
    if (exec_req) begin
      // an execute that lands while busy starts nothing, so it counts as refused
      refused_next = !(unlock_reg && region_ok && one_op &&
                       st_reg == flash_seq_pkg::st_idle);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer: start flash, hold cpu until done
  always_comb begin
    st_next = st_reg;
    busy_next = busy_reg;
    start_next = 1'b0;
    cmd_next = cmd_reg;
    unique case (st_reg)
      flash_seq_pkg::st_idle: begin
        if (exec_req && unlock_reg && region_ok && one_op) begin
          start_next = 1'b1;
          cmd_next = '{erase: req.wdata[`CTRL_ERASE_BIT], prog: req.wdata[`CTRL_PROG_BIT],
                       region: region_reg, addr: addr_reg, data: data_reg};
          st_next = req.wdata[`CTRL_ERASE_BIT] ? flash_seq_pkg::st_erase
                                                : flash_seq_pkg::st_prog;
          busy_next = req.wdata[`CTRL_ERASE_BIT] ? CW'(ERASE_CNT) : CW'(PROG_CNT);
        end
      end
      flash_seq_pkg::st_erase, flash_seq_pkg::st_prog: begin
        // finish on macro done or after the minimum time, whichever later
        if (busy_reg != '0) begin
          busy_next = busy_reg - CW'(1);
        end else if (flash_done) begin
          st_next = flash_seq_pkg::st_idle;
        end
      end
    endcase
    // hold registered from the next state so it rises with the start pulse
    hold_next = (st_next != flash_seq_pkg::st_idle);
  end
  // boot area reads only for code running from the boot area
  assign boot_ok_next = (region_reg == `REGION_BOOT) && exec_from_boot;

  //////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      key_reg <= `RESET_BYTE;
      region_reg <= `RESET_BYTE;
      data_reg <= `RESET_BYTE;
      addr_reg <= 16'h0000;
      ctrl_reg <= `RESET_BYTE;
      rdata_reg <= `RESET_BYTE;
      unlock_reg <= 1'b0;
      win_reg <= 8'h00;
      refused_reg <= 1'b0;
      st_reg <= flash_seq_pkg::st_idle;
      busy_reg <= '0;
      start_reg <= 1'b0;
      cmd_reg <= '0;
      boot_ok_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      key_reg <= key_next;
      region_reg <= region_next;
      data_reg <= data_next;
      addr_reg <= addr_next;
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
      unlock_reg <= unlock_next;
      win_reg <= win_next;
      refused_reg <= refused_next;
      st_reg <= st_next;
      busy_reg <= busy_next;
      start_reg <= start_next;
      cmd_reg <= cmd_next;
      boot_ok_reg <= boot_ok_next;
      hold_reg <= hold_next;
    end
  end

  assign rdata = rdata_reg;
  assign cpu_hold = hold_reg;
  assign flash_start = start_reg;
  assign flash_cmd = cmd_reg;
  assign boot_read_ok = boot_ok_reg;
  assign boot_after_reset = ctrl_reg[`CTRL_BOOT_BIT];

  //////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_exec_locked;
    exec_req && !unlock_reg;
  endsequence
  a_locked_no_start: assert property (@(posedge clk) disable iff (rst)
    s_exec_locked |=> !flash_start && !cpu_hold) else $error("locked command started");
  a_uid_refused: assert property (@(posedge clk) disable iff (rst)
    exec_req && region_reg == `REGION_UID |=> !flash_start) else $error("uid written");
  a_boot_refused: assert property (@(posedge clk) disable iff (rst)
    exec_req && region_reg == `REGION_BOOT |=> !flash_start) else $error("boot written");
  a_main_blocked: assert property (@(posedge clk) disable iff (rst)
    exec_req && main_write_block && region_reg == `REGION_MAIN |=> !flash_start)
    else $error("blocked main written");
  a_start_holds: assert property (@(posedge clk) disable iff (rst)
    flash_start |-> cpu_hold) else $error("start without hold");
  a_key_unlock: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == `OFS_KEY && req.wdata == 8'h03 |=> unlock_reg [*3] ##1 !unlock_reg)
    else $error("window length wrong");
  a_region_carried: assert property (@(posedge clk) disable iff (rst)
    flash_start |-> flash_cmd.region == `REGION_MAIN || flash_cmd.region == `REGION_EEPROM)
    else $error("bad region started");
  a_one_op: assert property (@(posedge clk) disable iff (rst)
    flash_start |-> flash_cmd.erase != flash_cmd.prog) else $error("two ops at once");
endmodule

// ---- inc/flash_seq_consts.svh ----
// offsets, field positions, reset values and timing counts of the flash sequencer
// assumes inclusion by bare name from the design file
`ifndef FLASH_SEQ_CONSTS_SVH
`define FLASH_SEQ_CONSTS_SVH
`define OFS_KEY 8'hF1
`define OFS_ADDR_LO 8'hF2
`define OFS_ADDR_HI 8'hF3
`define OFS_REGION 8'hF4
`define OFS_DATA 8'hF5
`define OFS_CTRL 8'hF6
`define OFS_STATUS 8'hF7
`define REGION_MAIN 8'h00
`define REGION_UID 8'h01
`define REGION_EEPROM 8'h02
`define REGION_BOOT 8'h03
`define CTRL_BOOT_BIT 7
`define CTRL_ERASE_BIT 5
`define CTRL_PROG_BIT 4
`define CMD_EXECUTE 2'h2
`define RESET_BYTE 8'h00
`define ERASE_TIME_NS 5000
`define PROG_TIME_NS 300
`define CLK_PERIOD_NS 10
`define ERASE_CYCLES ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- inc/flash_seq_pkg.sv ----
// types shared by the flash sequencer
// assumes flash_seq_consts.svh holds the numbers
package flash_seq_pkg;
  typedef enum logic [1:0] {st_idle, st_erase, st_prog} seq_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic erase;
    logic prog;
    logic [7:0] region;
    logic [15:0] addr;
    logic [7:0] data;
  } flash_cmd_t;
endpackage

// ---- tb/in_app_flash_program_erase_tb.sv ----
// self-checking bench for the flash erase and program sequencer
// assumes flash_seq, its package and constants header; bench drives flash_done itself
module in_app_flash_program_erase_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  flash_seq_pkg::reg_req_t req = '0;
  logic main_write_block = 1'b0;
  logic exec_from_boot = 1'b0;
  logic flash_done = 1'b0;
  logic [7:0] rdata;
  logic cpu_hold;
  logic flash_start;
  flash_seq_pkg::flash_cmd_t flash_cmd;
  logic boot_read_ok;
  logic boot_after_reset;
  int miscompares = 0;
  int num_checks = 0;
  int starts = 0;
  logic [7:0] v;
  // a program reuses the address of the erase before it when keep_addr is set
  logic keep_addr = 1'b0;
  logic [15:0] last_addr = 16'h0000;
  logic [7:0] rr;
  logic [7:0] kk;
  logic bb;
  ////////////////////////////////////////////////////////////////////////////////
  // short counts keep the hold phase brief
  flash_seq #(.ERASE_CNT(4), .PROG_CNT(2)) uut (
    .clk(clk), .rst(rst), .req(req), .main_write_block(main_write_block),
    .exec_from_boot(exec_from_boot), .flash_done(flash_done), .rdata(rdata),
    .cpu_hold(cpu_hold), .flash_start(flash_start), .flash_cmd(flash_cmd),
    .boot_read_ok(boot_read_ok), .boot_after_reset(boot_after_reset)
  );
  // clock and start pulse count, so a silent refusal can be told from a start
  always #5 clk = ~clk;
  always @(posedge clk) if (flash_start === 1'b1) starts <= starts + 1;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one-cycle strobes, a gap after each so no signal is driven twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req <= '0;
    #1 d = rdata;
  endtask
  // execute is taken four edges after the key, so a key below 4 has run out
  function automatic logic allowed(logic [7:0] r, logic [7:0] s, logic [7:0] k, logic b);
    return ((r == 8'h00 && !b) || r == 8'h02) && (s == 8'h10 || s == 8'h20) && k >= 8'h04;
  endfunction
  task automatic run_op(input logic [7:0] r, input logic [7:0] s, input logic [7:0] k,
                        input logic b);
    logic [15:0] a;
    logic [7:0] d;
    logic ok;
    int s0;
    int n;
    if (!keep_addr) last_addr = 16'($urandom);
    a = last_addr;
    d = 8'($urandom);
    ok = allowed(r, s, k, b);
    @(posedge clk) main_write_block <= b;
    // region, data, address, key, then select and execute
    wr(8'hF4, r);
    wr(8'hF5, d);
    wr(8'hF2, a[7:0]);
    wr(8'hF3, a[15:8]);
    wr(8'hF1, k);
    s0 = starts;
    wr(8'hF6, s);
    wr(8'hF6, s | 8'h02);
    #1 check(64'(flash_start), 64'(ok), "start");
    if (ok) begin
      check(64'(flash_cmd), 64'({s[5], s[4], r, a, d}), "command");
      repeat (8) @(posedge clk);
      #1 check(64'(cpu_hold), 64'h1, "hold before done");
      rd(8'hF7, v);
      check(64'(v[1]), 64'h1, "busy flag");
      check(64'(v[0]), 64'h0, "key used up");
      @(posedge clk) flash_done <= 1'b1;
      n = 0;
      while (cpu_hold !== 1'b0 && n < 4) begin
        @(posedge clk);
        #1 n++;
      end
      check(64'(cpu_hold), 64'h0, "hold after done");
      @(posedge clk) flash_done <= 1'b0;
    end else begin
      repeat (12) @(posedge clk);
      #1 check(64'(cpu_hold), 64'h0, "stall on refusal");
      check(64'(starts), 64'(s0), "start on refusal");
      rd(8'hF7, v);
      check(64'(v[2]), 64'h1, "refused flag");
    end
    // code reads go back to the main area before interrupts would return
    wr(8'hF4, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the roughly 1100 cycles the tests need
  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(80089));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // reset values, unmapped place and one readback
    for (int a = 8'hF0; a <= 8'hF8; a++) begin
      rd(8'(a), v);
      check(64'(v), 64'h0, "reset value");
    end
    wr(8'hF8, 8'hFF);
    rd(8'hF8, v);
    check(64'(v), 64'h0, "unmapped read");
    $display("test registers done");
    // corner cases of region, option, command and key window
    run_op(8'h00, 8'h20, 8'hF0, 1'b0);
    keep_addr = 1'b1;
    run_op(8'h00, 8'h10, 8'hF0, 1'b0);
    keep_addr = 1'b0;
    run_op(8'h02, 8'h20, 8'hF0, 1'b0);
    keep_addr = 1'b1;
    run_op(8'h02, 8'h10, 8'hF0, 1'b0);
    keep_addr = 1'b0;
    run_op(8'h01, 8'h10, 8'hF0, 1'b0);
    run_op(8'h01, 8'h20, 8'hF0, 1'b0);
    run_op(8'h03, 8'h10, 8'hF0, 1'b0);
    run_op(8'h00, 8'h10, 8'hF0, 1'b1);
    run_op(8'h00, 8'h30, 8'hF0, 1'b0);
    run_op(8'h02, 8'h20, 8'h03, 1'b0);
    run_op(8'h02, 8'h20, 8'h04, 1'b0);
    run_op(8'h00, 8'h10, 8'h00, 1'b0);
    $display("test corner operations done");
    // each random program follows an erase of the same place
    repeat (12) begin
      rr = 8'($urandom_range(3));
      kk = 8'($urandom_range(8'hF0, 2));
      bb = 1'($urandom);
      keep_addr = 1'b0;
      run_op(rr, 8'h20, kk, bb);
      keep_addr = 1'b1;
      run_op(rr, 8'h10, kk, bb);
    end
    keep_addr = 1'b0;
    $display("test random operations done");
    // boot-area reads only from boot code; boot flag follows control bit 7
    @(posedge clk) exec_from_boot <= 1'b1;
    wr(8'hF4, 8'h03);
    repeat (2) @(posedge clk);
    #1 check(64'(boot_read_ok), 64'h1, "boot read from boot code");
    @(posedge clk) exec_from_boot <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(64'(boot_read_ok), 64'h0, "boot read from main code");
    wr(8'hF4, 8'h00);
    wr(8'hF6, 8'h80);
    rd(8'hF6, v);
    check(64'({v, boot_after_reset}), 64'({8'h80, 1'b1}), "boot flag");
    $display("test boot area done");
    tally_and_finish();
  end
endmodule
